// File: rtl/conv_clamp_cal_regs.svh
/*
 * Register indexes, field positions, reset values and codes of the converter
 * clamp and calibration register bank.
 * Assumes the includer multiplies an index by four to form the byte address.
 */
`ifndef CONV_CLAMP_CAL_REGS_SVH
`define CONV_CLAMP_CAL_REGS_SVH

`define CONV_CFG_IDX 8'h07
`define CAL_ENABLE_IDX 8'h08
`define USER_GAIN_IDX 8'h09
`define OUTPUT_MODE_IDX 8'h10
`define CLAMP_STATUS_IDX 8'h11

`define ARM_SEL_LSB 0
`define NEG_CLAMP_LSB 2
`define POS_CLAMP_LSB 6
`define CLAMP_MODE_LSB 10

`define CONV_CFG_RESET 16'h0000
`define CAL_ENABLE_RESET 16'h0000
`define USER_GAIN_RESET 16'h0000
`define NEG_CLAMP_RESET 4'h0
`define ARM_SEL_RESET 2'h0

`define CLAMP_MODE_TRACK 2'h0
`define CLAMP_MODE_USER 2'h1
`define CLAMP_MODE_AUTO 2'h2

`define NEG_VOLT_9 4'h2
`define NEG_VOLT_15 4'h7
`define NEG_VOLT_18 4'h9
`define POS_VOLT_9 4'h3
`define POS_VOLT_15 4'h8
`define POS_VOLT_18 4'h9
`define CLAMP_LAST_VALID 4'h9

`define HTRANS_NONSEQ 2'h2
`define HSIZE_WORD 3'h2

`endif

// File: rtl/conv_clamp_cal_pkg.sv
/*
 * Types shared by the converter clamp and calibration register bank.
 * Defines the arm select codes itself; the other numbers come from the constants header.
 */
package conv_clamp_cal_pkg;

    typedef enum logic [1:0] {
        ARM_OFF = 2'h0,
        ARM_POS = 2'h1,
        ARM_BOTH = 2'h2,
        ARM_SPARE = 2'h3
    } arm_select_t;

    typedef struct packed {
        logic pos_arm_en;
        logic neg_arm_en;
        logic [1:0] clamp_config_mode;
        logic [3:0] positive_clamp_select;
        logic [3:0] negative_clamp_select;
        logic pos_clamp_valid;
        logic neg_clamp_valid;
        logic voltage_mode;
    } conv_ctrl_t;

    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } chan_word_t;

endpackage

// File: rtl/cal_gain_path.sv
/*
 * Channel data path that applies the user gain word when calibration is on.
 * Assumes its inputs come from logic on the same clock and an already
 * synchronised active-low reset.
 */
`timescale 1ns/100ps

module cal_gain_path
    import conv_clamp_cal_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Controls
    input wire logic cal_on,
    input wire logic [15:0] user_gain_word,
    // Data
    input wire chan_word_t data_in,
    output chan_word_t data_out
);

    chan_word_t next_out;
    logic [32:0] product;

    // Gain is 1 + word/65536, so a zero word is unity and the top saturates.
    always_comb begin
        product = {1'b0, data_in.data} * {1'b1, user_gain_word};
        next_out.valid = data_in.valid;
        if (cal_on) begin // RL5
            next_out.data = (product[32] != 1'b0) ? 16'hffff : product[31:16];
        end else begin
            next_out.data = data_in.data; // RL9
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_out <= '0;
        end else begin
            data_out <= next_out;
        end
    end

endmodule // cal_gain_path

// File: rtl/conv_clamp_cal_regs.sv
/*
 * AHB-Lite register bank for the converter clamp, arm and calibration
 * settings, driving converter control and the calibrated channel data.
 * Assumes a single AHB-Lite master and word-only transfers on a 100 MHz clk.
 */
// Register access over AHB-Lite was left to the implementer.
// Summary of operation
// [RL1] Negative clamp field bits 5:2, reset zero; codes 101x and 11xx invalid.
// [RL2] In voltage mode only negative clamp codes 0010, 0111, 1001 are valid.
// [RL3] Arm field bits 1:0: 00 both off, 01 positive only, 10 negative on.
// [RL4] Calibration enable register at 0x08, reset zero, bits 15:1 read/write.
// [RL5] Calibration enable bit 0 turns on calibration of channel data.
// [RL6] Gain calibration register at 0x09, reset zero.
// [RL7] Clamp select fields take writes only while clamp mode holds 01.
// [RL8] Gain register holds a sixteen-bit read/write user gain word.
// [RL9] With calibration off, channel data passes through unchanged.
`timescale 1ns/100ps
`include "conv_clamp_cal_regs.svh"

module conv_clamp_cal_regs
    import conv_clamp_cal_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Channel data
    input wire chan_word_t chan_in,
    output chan_word_t chan_out,
    // Converter control
    output conv_ctrl_t conv_ctrl
);

    logic rst_meta_n;
    logic rst_n;
    logic wr_pend;
    logic [7:0] wr_idx;
    logic [1:0] clamp_mode;
    logic [3:0] pos_clamp;
    logic [3:0] neg_clamp;
    logic [1:0] arm_sel;
    logic [15:0] cal_enable;
    logic [15:0] user_gain;
    logic voltage_mode;
    logic next_wr_pend;
    logic [7:0] next_wr_idx;
    logic [1:0] next_clamp_mode;
    logic [3:0] next_pos_clamp;
    logic [3:0] next_neg_clamp;
    logic [1:0] next_arm_sel;
    logic [15:0] next_cal_enable;
    logic [15:0] next_user_gain;
    logic next_voltage_mode;
    logic [31:0] next_hrdata;
    conv_ctrl_t next_conv_ctrl;
    logic addr_phase;
    logic [7:0] addr_idx;

    // Reset is asserted at once but released through two stages.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_n <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n <= rst_meta_n;
        end
    end

    // An address outside the low kilobyte or off a word boundary maps nowhere.
    function automatic logic idx_mapped(input logic [31:0] addr, input logic [7:0] idx);
        idx_mapped = (addr[31:10] == 22'h0) && (addr[1:0] == 2'h0) && (addr[9:2] == idx);
    endfunction

    function automatic logic neg_clamp_ok(input logic [3:0] code, input logic volt);
        if (code > `CLAMP_LAST_VALID) begin
            neg_clamp_ok = 1'b0; // RL1
        end else if (volt) begin
            neg_clamp_ok = (code == `NEG_VOLT_9) || (code == `NEG_VOLT_15) ||
                (code == `NEG_VOLT_18); // RL2
        end else begin
            neg_clamp_ok = 1'b1;
        end
    endfunction

    function automatic logic pos_clamp_ok(input logic [3:0] code, input logic volt);
        pos_clamp_ok = !volt || (code == `POS_VOLT_9) || (code == `POS_VOLT_15) ||
            (code == `POS_VOLT_18);
    endfunction

    assign addr_phase = hsel && hready && (htrans == `HTRANS_NONSEQ) &&
        (hsize == `HSIZE_WORD);
    assign addr_idx = haddr[9:2];

    // Register file next state; the data phase write lands at its closing edge.
    always_comb begin
        next_clamp_mode = clamp_mode;
        next_pos_clamp = pos_clamp;
        next_neg_clamp = neg_clamp;
        next_arm_sel = arm_sel;
        next_cal_enable = cal_enable;
        next_user_gain = user_gain;
        next_voltage_mode = voltage_mode;
        if (wr_pend) begin
            unique case (wr_idx)
                `CONV_CFG_IDX: begin
                    next_clamp_mode = hwdata[`CLAMP_MODE_LSB +: 2];
                    next_arm_sel = hwdata[`ARM_SEL_LSB +: 2]; // RL3
                    if (clamp_mode == `CLAMP_MODE_USER) begin
                        next_pos_clamp = hwdata[`POS_CLAMP_LSB +: 4]; // RL7
                        next_neg_clamp = hwdata[`NEG_CLAMP_LSB +: 4]; // RL1
                    end
                end
                `CAL_ENABLE_IDX: begin
                    next_cal_enable = hwdata[15:0]; // RL4
                end
                `USER_GAIN_IDX: begin
                    next_user_gain = hwdata[15:0]; // RL8
                end
                `OUTPUT_MODE_IDX: begin
                    next_voltage_mode = hwdata[0];
                end
                default: begin
                end
            endcase
        end
    end

    // Bus side: reads see a write that completes on the same edge.
    always_comb begin
        next_wr_pend = addr_phase && hwrite && (haddr[31:10] == 22'h0) &&
            (haddr[1:0] == 2'h0);
        next_wr_idx = addr_idx;
        next_hrdata = hrdata;
        if (addr_phase && !hwrite) begin
            next_hrdata = 32'h0;
            if (idx_mapped(haddr, `CONV_CFG_IDX)) begin
                next_hrdata[11:0] = {next_clamp_mode, next_pos_clamp, next_neg_clamp,
                    next_arm_sel};
            end else if (idx_mapped(haddr, `CAL_ENABLE_IDX)) begin
                next_hrdata[15:0] = next_cal_enable;
            end else if (idx_mapped(haddr, `USER_GAIN_IDX)) begin
                next_hrdata[15:0] = next_user_gain; // RL6
            end else if (idx_mapped(haddr, `OUTPUT_MODE_IDX)) begin
                next_hrdata[0] = next_voltage_mode;
            end else if (idx_mapped(haddr, `CLAMP_STATUS_IDX)) begin
                next_hrdata[3:0] = {next_conv_ctrl.neg_arm_en, next_conv_ctrl.pos_arm_en,
                    next_conv_ctrl.pos_clamp_valid, next_conv_ctrl.neg_clamp_valid};
            end
        end
    end

    // Converter control follows the register values from the same edge.
    always_comb begin
        next_conv_ctrl.pos_arm_en = (next_arm_sel == ARM_POS) || (next_arm_sel == ARM_BOTH);
        next_conv_ctrl.neg_arm_en = (next_arm_sel == ARM_BOTH); // RL3
        next_conv_ctrl.clamp_config_mode = next_clamp_mode;
        next_conv_ctrl.positive_clamp_select = next_pos_clamp;
        next_conv_ctrl.negative_clamp_select = next_neg_clamp;
        next_conv_ctrl.pos_clamp_valid = pos_clamp_ok(next_pos_clamp, next_voltage_mode);
        next_conv_ctrl.neg_clamp_valid = neg_clamp_ok(next_neg_clamp, next_voltage_mode);
        next_conv_ctrl.voltage_mode = next_voltage_mode;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend <= 1'b0;
            wr_idx <= 8'h00;
            clamp_mode <= `CLAMP_MODE_TRACK;
            pos_clamp <= 4'h0;
            neg_clamp <= `NEG_CLAMP_RESET;
            arm_sel <= `ARM_SEL_RESET;
            cal_enable <= `CAL_ENABLE_RESET;
            user_gain <= `USER_GAIN_RESET;
            voltage_mode <= 1'b0;
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            conv_ctrl <= '0;
        end else begin
            wr_pend <= next_wr_pend;
            wr_idx <= next_wr_idx;
            clamp_mode <= next_clamp_mode;
            pos_clamp <= next_pos_clamp;
            neg_clamp <= next_neg_clamp;
            arm_sel <= next_arm_sel;
            cal_enable <= next_cal_enable;
            user_gain <= next_user_gain;
            voltage_mode <= next_voltage_mode;
            hrdata <= next_hrdata;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            conv_ctrl <= next_conv_ctrl;
        end
    end

    cal_gain_path u_cal_gain_path (
        .clk(clk),
        .rst_n(rst_n),
        .cal_on(cal_enable[0]), // RL5
        .user_gain_word(user_gain),
        .data_in(chan_in),
        .data_out(chan_out)
    );

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_addr(logic [7:0] idx, logic wr);
        addr_phase && (hwrite == wr) && idx_mapped(haddr, idx);
    endsequence

    sequence s_cfg_write_user;
        s_addr(`CONV_CFG_IDX, 1'b1) ##1 (clamp_mode == `CLAMP_MODE_USER);
    endsequence

    property p_clamp_locked;
        (wr_pend && wr_idx == `CONV_CFG_IDX && clamp_mode != `CLAMP_MODE_USER) |=>
            $stable(neg_clamp) && $stable(pos_clamp);
    endproperty
    a_clamp_locked: assert property (p_clamp_locked) // RL7
        else $error("clamp select changed outside user clamp mode");

    property p_neg_written;
        logic [3:0] v;
        s_cfg_write_user ##0 (1'b1, v = hwdata[5:2]) |=>
            (neg_clamp == v) && (conv_ctrl.negative_clamp_select == v);
    endproperty
    a_neg_written: assert property (p_neg_written) // RL1
        else $error("negative clamp select did not take the written code");

    property p_volt_valid;
        conv_ctrl.voltage_mode |-> conv_ctrl.neg_clamp_valid ==
            (conv_ctrl.negative_clamp_select inside {4'h2, 4'h7, 4'h9});
    endproperty
    a_volt_valid: assert property (p_volt_valid) // RL2
        else $error("voltage mode negative clamp validity wrong");

    property p_high_codes_invalid;
        (conv_ctrl.negative_clamp_select[3:1] == 3'h5 ||
            conv_ctrl.negative_clamp_select[3:2] == 2'h3) |-> !conv_ctrl.neg_clamp_valid;
    endproperty
    a_high_codes_invalid: assert property (p_high_codes_invalid) // RL1
        else $error("negative clamp code above 1001 shown valid");

    property p_arm_decode;
        (wr_pend && wr_idx == `CONV_CFG_IDX) |=>
            (conv_ctrl.pos_arm_en == ($past(hwdata[1:0]) inside {2'h1, 2'h2})) &&
            (conv_ctrl.neg_arm_en == ($past(hwdata[1:0]) == 2'h2));
    endproperty
    a_arm_decode: assert property (p_arm_decode) // RL3
        else $error("arm enables do not follow the arm select code");

    property p_cal_read;
        s_addr(`CAL_ENABLE_IDX, 1'b0) |=> hrdata == {16'h0, cal_enable};
    endproperty
    a_cal_read: assert property (p_cal_read) // RL4
        else $error("calibration enable read data wrong");

    property p_gain_roundtrip;
        logic [15:0] v;
        (s_addr(`USER_GAIN_IDX, 1'b1) ##1 (1'b1, v = hwdata[15:0]) ##0
            s_addr(`USER_GAIN_IDX, 1'b0)) |=> hrdata == {16'h0, v};
    endproperty
    a_gain_roundtrip: assert property (p_gain_roundtrip) // RL6
        else $error("gain word read back differs from the word written");

    property p_bypass;
        (!cal_enable[0] && chan_in.valid) |=>
            chan_out.valid && (chan_out.data == $past(chan_in.data));
    endproperty
    a_bypass: assert property (p_bypass) // RL9
        else $error("uncalibrated channel data was altered");

    property p_cal_applies;
        (cal_enable[0] && chan_in.valid && user_gain[15:8] != 8'h0 &&
            chan_in.data[15:8] != 8'h0 && !chan_in.data[15]) |=>
            chan_out.data > $past(chan_in.data);
    endproperty
    a_cal_applies: assert property (p_cal_applies) // RL5
        else $error("calibration enabled but gain not applied");

endmodule // conv_clamp_cal_regs

// File: tb/conv_clamp_cal_regs_bench.sv
/*
 * Self-checking bench for the converter clamp and calibration register bank.
 * Assumes the constants header and package of the design, and a single
 * AHB-Lite master whose hready is the slave's own hreadyout.
 */
`timescale 1ns/100ps
`include "conv_clamp_cal_regs.svh"

module conv_clamp_cal_regs_bench
    import conv_clamp_cal_pkg::*;
;
    logic clk;
    logic nrst;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hready;
    logic [31:0] hwdata;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    chan_word_t chan_in;
    chan_word_t chan_out;
    conv_ctrl_t conv_ctrl;
    int bad_count;
    int total_checks;
    logic [31:0] rd;

    assign hready = hreadyout;

    conv_clamp_cal_regs uut (
        .clk(clk),
        .nrst(nrst),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hready),
        .hwdata(hwdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .chan_in(chan_in),
        .chan_out(chan_out),
        .conv_ctrl(conv_ctrl)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic [31:0] ba(input logic [7:0] idx);
        return {22'h0, idx, 2'b00};
    endfunction

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // The request is held until hready is seen high; read data is taken at the data phase end.
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= `HTRANS_NONSEQ;
        hwrite <= wr;
        hsize <= `HSIZE_WORD;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, ba(idx), d, q);
    endtask

    task automatic rd_reg(input logic [7:0] idx, output logic [31:0] q);
        bus(1'b0, ba(idx), 32'h0, q);
    endtask

    // The write's data phase overlaps the read's address phase of the same register.
    task automatic wr_then_rd(input logic [7:0] idx, input logic [31:0] d,
                              output logic [31:0] q);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= ba(idx);
        htrans <= `HTRANS_NONSEQ;
        hwrite <= 1'b1;
        hsize <= `HSIZE_WORD;
        do @(posedge clk); while (hready !== 1'b1);
        hwrite <= 1'b0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= 32'h0;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
    endtask

    // Sends one channel word and looks at the answer once it has settled.
    task automatic chan(input logic [15:0] d, input logic [15:0] exp);
        @(posedge clk);
        chan_in <= '{valid: 1'b1, data: d};
        @(posedge clk);
        chan_in <= '{valid: 1'b0, data: 16'h0};
        @(negedge clk);
        cmp({15'h0, chan_out.valid, chan_out.data}, {15'h0, 1'b1, exp});
    endtask

    task automatic test_reset_values();
        rd_reg(`CAL_ENABLE_IDX, rd);
        cmp(rd, 32'h0);
        rd_reg(`USER_GAIN_IDX, rd);
        cmp(rd, 32'h0);
        rd_reg(`CONV_CFG_IDX, rd);
        cmp(rd, 32'h0);
        cmp({17'h0, conv_ctrl}, 32'h0000_0006);
        cmp({31'h0, hresp}, 32'h0);
    endtask

    task automatic test_cal_regs();
        wr(`CAL_ENABLE_IDX, 32'hffff_ffff);
        rd_reg(`CAL_ENABLE_IDX, rd);
        cmp(rd, 32'h0000_ffff);
        wr(`USER_GAIN_IDX, 32'h1234_a5c3);
        rd_reg(`USER_GAIN_IDX, rd);
        cmp(rd, 32'h0000_a5c3);
        wr_then_rd(`USER_GAIN_IDX, 32'h0000_5a3c, rd);
        cmp(rd, 32'h0000_5a3c);
        wr(8'h20, 32'h0000_0000);
        rd_reg(8'h20, rd);
        cmp(rd, 32'h0);
        rd_reg(`CAL_ENABLE_IDX, rd);
        cmp(rd, 32'h0000_ffff);
    endtask

    // Gain is set before calibration is off, so a pass-through proves the gain is bypassed.
    task automatic test_cal_path();
        wr(`USER_GAIN_IDX, 32'h8000);
        wr(`CAL_ENABLE_IDX, 32'h0);
        chan(16'h1000, 16'h1000);
        chan(16'hf000, 16'hf000);
        wr(`CAL_ENABLE_IDX, 32'h1);
        chan(16'h1000, 16'h1800);
        chan(16'hf000, 16'hffff);
        wr(`CAL_ENABLE_IDX, 32'h0);
        chan(16'h1000, 16'h1000);
    endtask

    task automatic test_clamp_lock();
        wr(`CONV_CFG_IDX, 32'h0000_021d);
        rd_reg(`CONV_CFG_IDX, rd);
        cmp(rd, 32'h0000_0001);
        wr(`CONV_CFG_IDX, 32'h0000_0400);
        wr(`CONV_CFG_IDX, 32'h0000_0624);
        rd_reg(`CONV_CFG_IDX, rd);
        cmp(rd, 32'h0000_0624);
        wr(`CONV_CFG_IDX, 32'h0000_0008);
        rd_reg(`CONV_CFG_IDX, rd);
        cmp(rd, 32'h0000_0008);
        wr(`CONV_CFG_IDX, 32'h0000_0224);
        rd_reg(`CONV_CFG_IDX, rd);
        cmp(rd, 32'h0000_0008);
    endtask

    task automatic test_arm_codes();
        logic [1:0] exp [4];
        exp[0] = 2'b00;
        exp[1] = 2'b10;
        exp[2] = 2'b11;
        exp[3] = 2'b00;
        for (int c = 0; c < 4; c++) begin
            wr(`CONV_CFG_IDX, 32'h0400 | c);
            @(negedge clk);
            cmp({30'h0, conv_ctrl.pos_arm_en, conv_ctrl.neg_arm_en}, {30'h0, exp[c]});
        end
    endtask

    // Every negative clamp code in both output modes, with its expected valid flag.
    task automatic test_clamp_codes();
        logic v;
        wr(`CONV_CFG_IDX, 32'h0000_0400);
        for (int vm = 0; vm < 2; vm++) begin
            wr(`OUTPUT_MODE_IDX, vm);
            for (int c = 0; c < 16; c++) begin
                v = vm ? (c == 2 || c == 7 || c == 9) : (c < 10);
                wr(`CONV_CFG_IDX, 32'h0400 | (c << 2));
                rd_reg(`CONV_CFG_IDX, rd);
                cmp(rd, 32'h0400 | (c << 2));
                cmp({26'h0, conv_ctrl.voltage_mode, conv_ctrl.neg_clamp_valid,
                     conv_ctrl.negative_clamp_select}, {26'h0, vm[0], v, c[3:0]});
                rd_reg(`CLAMP_STATUS_IDX, rd);
                cmp(rd, {28'h0, 2'b00, ~vm[0], v});
            end
        end
    endtask

    initial begin
        nrst = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = `HSIZE_WORD;
        hwdata = 32'h0;
        chan_in = '0;
        bad_count = 0;
        total_checks = 0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        test_reset_values();
        test_cal_regs();
        test_cal_path();
        test_clamp_lock();
        test_arm_codes();
        test_clamp_codes();
        repeat (2) @(posedge clk);
        close_out();
    end

    // The tests take well under two thousand cycles.
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        close_out();
    end
endmodule // conv_clamp_cal_regs_bench
